// File: hw/svf_host.sv
// Interrupt controller end: takes shared vectors and exposes them over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module svf_host
  import svf_pkg::*;
#(
  parameter int ADDR_W = 8 // AXI address width.
)
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous active-low reset.
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic irq, // Level interrupt, high while an unmasked status bit is set.
  svf_link_if.host link // Link to the device end.
);
  import svf_pkg::*;

  // Held write address and data, taken in either order.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic wr_hit;
  // Software registers.
  logic [2:0] ctrl;
  logic [1:0] status;
  logic [1:0] mask;
  logic [15:0] vec_q;
  logic vec_held;
  logic take;
  logic [1:0] st_set;
  logic flag_wr_q;
  logic [7:0] flag_wdata_q;
  logic [31:0] rd_word;
  logic rd_hit;

  // Address and data channels each accept one item until the response leaves.
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_hit = (aw_addr_q == SVF_OFS_CTRL) | (aw_addr_q == SVF_OFS_STATUS) | (aw_addr_q == SVF_OFS_MASK) |
    (aw_addr_q == SVF_OFS_FLAGS) | (aw_addr_q == SVF_OFS_EOI);

  // Write channel capture and response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SVF_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr_q <= 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? SVF_RESP_OKAY : SVF_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Accept a vector when enabled and none is under service.
  assign take = ctrl[SVF_CTRL_ACCEPT] & link.vector_valid & ~vec_held;
  assign link.vector_ack = take;

  // Status events: vector taken, and taken while no determination flag is set.
  always_comb
  begin
    st_set = '0;
    st_set[SVF_ST_TAKEN] = take;
    st_set[SVF_ST_NOFLAG] = take & (link.flag_rdata == 8'h00);
  end

  // Control, mask and status registers; status clears by writing one, set wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= SVF_CTRL_RESET;
      mask <= SVF_ST_RESET;
      status <= SVF_ST_RESET;
    end
    else
    begin
      if (do_write && w_strb_q[0] && aw_addr_q == SVF_OFS_CTRL)
      begin
        ctrl <= w_data_q[2:0];
      end
      if (do_write && w_strb_q[0] && aw_addr_q == SVF_OFS_MASK)
      begin
        mask <= w_data_q[1:0];
      end
      if (do_write && w_strb_q[0] && aw_addr_q == SVF_OFS_STATUS)
      begin
        status <= (status & ~w_data_q[1:0]) | st_set;
      end
      else
      begin
        status <= status | st_set;
      end
    end
  end

  // Vector under service, released by an end-of-interrupt write.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vec_held <= 1'b0;
      vec_q <= '0;
    end
    else if (take)
    begin
      vec_held <= 1'b1;
      vec_q <= link.vector_addr;
    end
    else if (do_write && w_strb_q[0] && aw_addr_q == SVF_OFS_EOI)
    begin
      vec_held <= 1'b0;
    end
  end

  // Flag writes pass to the device as a one-cycle strobe.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_wr_q <= 1'b0;
      flag_wdata_q <= 8'hff;
    end
    else
    begin
      flag_wr_q <= do_write & w_strb_q[0] & (aw_addr_q == SVF_OFS_FLAGS);
      flag_wdata_q <= w_data_q[7:0];
    end
  end
  assign link.flag_wr = flag_wr_q;
  assign link.flag_wdata = flag_wdata_q;
  assign link.wake_select = {ctrl[SVF_CTRL_LIN1_SEL], ctrl[SVF_CTRL_LIN0_SEL]};
  assign irq = |(status & mask);

  // Read decode.
  always_comb
  begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (8'(s_axi_araddr))
      SVF_OFS_CTRL: rd_word = {29'h0, ctrl};
      SVF_OFS_STATUS: rd_word = {30'h0, status};
      SVF_OFS_MASK: rd_word = {30'h0, mask};
      SVF_OFS_VECTOR: rd_word = {15'h0, vec_held, vec_q};
      SVF_OFS_FLAGS: rd_word = {24'h0, link.flag_rdata};
      SVF_OFS_AUX: rd_word = {28'h0, link.aux_status};
      SVF_OFS_EOI: rd_word = '0;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel: one read at a time, answered the cycle after acceptance.
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SVF_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? SVF_RESP_OKAY : SVF_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: hw/svf_pkg.sv
// Package of constants shared by the shared-vector source flag device and its controller.
package svf_pkg;
  // Number of shared vectors that the device arbitrates.
  localparam int SVF_NUM_VEC = 10;
  // Vector addresses, entry index order is also the fixed priority order.
  localparam logic [15:0] SVF_VEC_ADDR [0:SVF_NUM_VEC-1] = '{
    16'h0010, 16'h0012, 16'h0014, 16'h002a, 16'h0036,
    16'h0038, 16'h003a, 16'h003c, 16'h004a, 16'h0064};
  // Index of each shared vector within the pending array.
  localparam int SVF_VIDX_EDGE4 = 0;
  localparam int SVF_VIDX_EDGE5 = 1;
  localparam int SVF_VIDX_EDGE13 = 2;
  localparam int SVF_VIDX_EDGE8 = 3;
  localparam int SVF_VIDX_EDGE6 = 4;
  localparam int SVF_VIDX_EDGE7 = 5;
  localparam int SVF_VIDX_EDGE9 = 6;
  localparam int SVF_VIDX_EDGE10 = 7;
  localparam int SVF_VIDX_EDGE11 = 8;
  localparam int SVF_VIDX_EDGE12 = 9;
  // Bit positions in the source determination flag register.
  localparam int SVF_BIT_EDGE4 = 0;
  localparam int SVF_BIT_EDGE5 = 1;
  localparam int SVF_BIT_EDGE8 = 2;
  localparam int SVF_BIT_CMP0 = 6;
  localparam int SVF_BIT_EDGE13 = 7;
  // Reset value of the source determination flag register.
  localparam logic [7:0] SVF_FLAGS_RESET = 8'h00;
  // Auxiliary status bit positions: pll selected, pll select, alarm, periodic.
  localparam int SVF_AUX_PLLS = 0;
  localparam int SVF_AUX_PLLC = 1;
  localparam int SVF_AUX_ALARM = 2;
  localparam int SVF_AUX_PERIOD = 3;
  // Controller register byte offsets.
  localparam logic [7:0] SVF_OFS_CTRL = 8'h00;
  localparam logic [7:0] SVF_OFS_STATUS = 8'h04;
  localparam logic [7:0] SVF_OFS_MASK = 8'h08;
  localparam logic [7:0] SVF_OFS_VECTOR = 8'h0c;
  localparam logic [7:0] SVF_OFS_FLAGS = 8'h10;
  localparam logic [7:0] SVF_OFS_AUX = 8'h14;
  localparam logic [7:0] SVF_OFS_EOI = 8'h18;
  // Control register fields and reset value.
  localparam int SVF_CTRL_LIN0_SEL = 0;
  localparam int SVF_CTRL_LIN1_SEL = 1;
  localparam int SVF_CTRL_ACCEPT = 2;
  localparam logic [2:0] SVF_CTRL_RESET = 3'h0;
  // Status and mask fields: vector taken, vector taken with no flag set.
  localparam int SVF_ST_TAKEN = 0;
  localparam int SVF_ST_NOFLAG = 1;
  localparam logic [1:0] SVF_ST_RESET = 2'h0;
  // AXI response codes.
  localparam logic [1:0] SVF_RESP_OKAY = 2'h0;
  localparam logic [1:0] SVF_RESP_SLVERR = 2'h2;
endpackage

// File: hw/svf_link_if.sv
// Interface joining the source flag device and the interrupt controller end.
`timescale 1ns/1ps
`default_nettype none
interface svf_link_if;
  logic vector_valid; // A shared vector is pending.
  logic [15:0] vector_addr; // Address of the highest priority pending vector.
  logic vector_ack; // One-cycle acceptance of the presented vector.
  logic flag_wr; // One-cycle write strobe to the determination flags.
  logic [7:0] flag_wdata; // Write data, zero bits clear flags.
  logic [7:0] flag_rdata; // Current determination flag register.
  logic [3:0] aux_status; // PLL and RTC identification bits.
  logic [1:0] wake_select; // Per pair, one selects the LIN wake-up source.
  // Device end of the link.
  modport dev (
    output vector_valid, vector_addr, flag_rdata, aux_status,
    input vector_ack, flag_wr, flag_wdata, wake_select
  );
  // Controller end of the link.
  modport host (
    input vector_valid, vector_addr, flag_rdata, aux_status,
    output vector_ack, flag_wr, flag_wdata, wake_select
  );
endinterface
`default_nettype wire

// File: hw/svf_device.sv
// Shared vector arbitration and source determination flags of the device.
//
// Operation
// - Edge4/stack, edge5/cmp0, edge13/clockstop share vectors.
// - Edge8 and RTC event share vector 002A.
// - Edges 6,7,9,10 share with timers, unflagged.
// - Software enables one source per LIN pair.
// - Edge4 request sets flag bit 0.
// - Edge5 sets bit 1, comparator0 bit 6.
// - Edge13 sets bit 7; clockstop via PLL bits.
// - Edge8 sets bit 2; RTC via its flags.
// - Stack monitor found by software stack check.
// - Repeat event re-pends request despite cleared flag.
// - Edge4 during handling re-takes shared vector later.
// - Handler clears its flag before ending service.
// - Safety monitor interrupts get high priority.
`timescale 1ns/1ps
`default_nettype none
module svf_device
  import svf_pkg::*;
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous active-low reset.
  input wire logic edge_input_4_request, // Edge input 4 event pulse.
  input wire logic edge_input_5_request, // Edge input 5 event pulse.
  input wire logic edge_input_6_request, // Edge input 6 event pulse.
  input wire logic edge_input_7_request, // Edge input 7 event pulse.
  input wire logic edge_input_8_request, // Edge input 8 event pulse.
  input wire logic edge_input_9_request, // Edge input 9 event pulse.
  input wire logic edge_input_10_request, // Edge input 10 event pulse.
  input wire logic edge_input_11_request, // Edge input 11 event pulse.
  input wire logic edge_input_12_request, // Edge input 12 event pulse.
  input wire logic edge_input_13_request, // Edge input 13 event pulse.
  input wire logic stack_monitor_request, // Stack pointer monitor event pulse.
  input wire logic comparator0_request, // Comparator 0 detection pulse.
  input wire logic clock_stop_request, // Clock-stop monitor event pulse.
  input wire logic rtc_event_request, // RTC periodic or alarm event pulse.
  input wire logic timer1_ch1_upper_request, // Timer array 1 channel 1 upper pulse.
  input wire logic timer1_ch3_upper_request, // Timer array 1 channel 3 upper pulse.
  input wire logic timer0_ch1_upper_request, // Timer array 0 channel 1 upper pulse.
  input wire logic timer0_ch3_upper_request, // Timer array 0 channel 3 upper pulse.
  input wire logic lin_port0_wakeup_request, // LIN port 0 wake-up pulse.
  input wire logic lin_port1_wakeup_request, // LIN port 1 wake-up pulse.
  input wire logic pll_selected_status, // PLL selected status level.
  input wire logic pll_select_control, // PLL select control level.
  input wire logic alarm_match_flag, // RTC alarm match flag level.
  input wire logic periodic_event_flag, // RTC periodic event flag level.
  svf_link_if.dev link // Link to the controller end.
);
  import svf_pkg::*;

  // Merged event of each shared vector.
  logic [SVF_NUM_VEC-1:0] vec_event;
  // Pending request bit of each shared vector.
  logic [SVF_NUM_VEC-1:0] pending;
  // Pending bits as they will be after this edge.
  logic [SVF_NUM_VEC-1:0] next_pending;
  // Index of the vector presented to the controller.
  logic [3:0] sel_idx;
  // Index of the highest priority vector in next_pending.
  logic [3:0] next_sel;
  // Presented vector valid and address registers.
  logic valid_q;
  logic [15:0] addr_q;
  // Determination flag register and its set events.
  logic [7:0] flags;
  logic [7:0] flag_set;
  logic [7:0] next_flags;
  // Registered identification levels for the clock-stop and RTC sources.
  logic [3:0] aux_q;

  // Each pair of sources folds onto its shared vector.
  always_comb
  begin
    vec_event = '0;
    vec_event[SVF_VIDX_EDGE4] = edge_input_4_request | stack_monitor_request;
    vec_event[SVF_VIDX_EDGE5] = edge_input_5_request | comparator0_request;
    vec_event[SVF_VIDX_EDGE13] = edge_input_13_request | clock_stop_request;
    vec_event[SVF_VIDX_EDGE8] = edge_input_8_request | rtc_event_request;
    vec_event[SVF_VIDX_EDGE6] = edge_input_6_request | timer1_ch1_upper_request;
    vec_event[SVF_VIDX_EDGE7] = edge_input_7_request | timer1_ch3_upper_request;
    vec_event[SVF_VIDX_EDGE9] = edge_input_9_request | timer0_ch1_upper_request;
    vec_event[SVF_VIDX_EDGE10] = edge_input_10_request | timer0_ch3_upper_request;
    // Only the selected member of each LIN pair can raise the vector.
    if (link.wake_select[0])
    begin
      vec_event[SVF_VIDX_EDGE11] = lin_port0_wakeup_request;
    end
    else
    begin
      vec_event[SVF_VIDX_EDGE11] = edge_input_11_request;
    end
    if (link.wake_select[1])
    begin
      vec_event[SVF_VIDX_EDGE12] = lin_port1_wakeup_request;
    end
    else
    begin
      vec_event[SVF_VIDX_EDGE12] = edge_input_12_request;
    end
  end

  // Per vector, a new event sets the pending bit even in the acceptance cycle,
  // so a repeat edge during handling brings the vector back afterwards.
  genvar gi;
  generate
    for (gi = 0; gi < SVF_NUM_VEC; gi++)
    begin : g_pend
      assign next_pending[gi] = vec_event[gi] |
        (pending[gi] & ~(link.vector_ack & valid_q & (sel_idx == 4'(gi))));
    end
  endgenerate

  // Lowest index wins, which keeps the stack monitor vector first.
  always_comb
  begin
    next_sel = '0;
    for (int i = SVF_NUM_VEC - 1; i >= 0; i--)
    begin
      if (next_pending[i])
      begin
        next_sel = 4'(i);
      end
    end
  end

  // Pending register, updated from its next value.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pending <= '0;
    end
    else
    begin
      pending <= next_pending;
    end
  end

  // Presented vector registers follow the next pending state so that
  // they never lag an acceptance.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      valid_q <= 1'b0;
      sel_idx <= '0;
      addr_q <= '0;
    end
    else
    begin
      valid_q <= |next_pending;
      sel_idx <= next_sel;
      addr_q <= SVF_VEC_ADDR[next_sel];
    end
  end

  // Flag set events; stack, clock-stop and RTC sources have no flag bit.
  always_comb
  begin
    flag_set = '0;
    flag_set[SVF_BIT_EDGE4] = edge_input_4_request;
    flag_set[SVF_BIT_EDGE5] = edge_input_5_request;
    flag_set[SVF_BIT_CMP0] = comparator0_request;
    flag_set[SVF_BIT_EDGE13] = edge_input_13_request;
    flag_set[SVF_BIT_EDGE8] = edge_input_8_request;
  end

  // A written zero clears a flag, a written one keeps it, and a set event
  // in the same cycle wins over the clear.
  always_comb
  begin
    next_flags = flag_set | (flags & ~(link.flag_wr ? ~link.flag_wdata : 8'h00));
  end

  // Determination flag register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags <= SVF_FLAGS_RESET;
    end
    else
    begin
      flags <= next_flags;
    end
  end

  // Identification levels are registered for the handler to read.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aux_q <= '0;
    end
    else
    begin
      aux_q[SVF_AUX_PLLS] <= pll_selected_status;
      aux_q[SVF_AUX_PLLC] <= pll_select_control;
      aux_q[SVF_AUX_ALARM] <= alarm_match_flag;
      aux_q[SVF_AUX_PERIOD] <= periodic_event_flag;
    end
  end

  // Outputs toward the controller all come from registers.
  assign link.vector_valid = valid_q;
  assign link.vector_addr = addr_q;
  assign link.flag_rdata = flags;
  assign link.aux_status = aux_q;
endmodule
`default_nettype wire

// File: testbench/svf_props.sv
// Concurrent checks on the link between the source flag device and the controller end.
`timescale 1ns/1ps
`default_nettype none
module svf_props
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic vector_valid, // A shared vector is pending.
  input wire logic [15:0] vector_addr, // Presented vector address.
  input wire logic vector_ack, // Acceptance of the presented vector.
  input wire logic flag_wr, // Write strobe to the determination flags.
  input wire logic [7:0] flag_wdata, // Flag write data.
  input wire logic [7:0] flag_rdata, // Determination flags.
  input wire logic [3:0] aux_status, // Identification bits of the PLL and the RTC.
  input wire logic [1:0] wake_select // Wake-up selection per pair.
);
  // Copies of the last cycle, so that a flag change can be tied to the write that caused it.
  logic [7:0] prev_flags;
  logic prev_wr;
  logic [7:0] prev_wdata;

  // Capture the previous cycle; cleared in reset so no stale values leak across it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_flags <= 8'h00;
      prev_wr <= 1'b0;
      prev_wdata <= 8'h00;
    end
    else
    begin
      prev_flags <= flag_rdata;
      prev_wr <= flag_wr;
      prev_wdata <= flag_wdata;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_flag_spare: assert property (flag_rdata[5:3] == 3'h0)
    else $error("unassigned flag bits read non-zero");
  chk_flag_hold: assert property (((prev_flags & ~flag_rdata) != 8'h00) |-> prev_wr)
    else $error("flag bit fell without a flag write");
  chk_ones_keep: assert property (prev_wr |-> ((flag_rdata & prev_flags & prev_wdata) == (prev_flags & prev_wdata)))
    else $error("writing one changed a set flag");
  chk_set_pends: assert property (((flag_rdata & ~prev_flags) != 8'h00) |-> vector_valid)
    else $error("flag set without a pending vector");
  chk_vec_legal: assert property (vector_valid |-> vector_addr inside {16'h0010, 16'h0012, 16'h0014, 16'h002a,
    16'h0036, 16'h0038, 16'h003a, 16'h003c, 16'h004a, 16'h0064})
    else $error("vector address outside the table");
  chk_ack_valid: assert property (vector_ack |-> vector_valid)
    else $error("vector accepted while none pending");
  chk_ack_once: assert property (vector_ack |=> !vector_ack [*3])
    else $error("vector accepted again too soon");
  chk_wr_pulse: assert property (flag_wr |=> !flag_wr)
    else $error("flag write strobe longer than one cycle");
  chk_pend_stands: assert property (vector_valid && !vector_ack |=> vector_valid)
    else $error("pending vector vanished without acceptance");
endmodule
`default_nettype wire

// File: testbench/test_shared_vector_source_flags.sv
// Self-checking bench: device and controller end joined by the link, driven over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module test_shared_vector_source_flags;
  import svf_pkg::*;
  // Expected vector per source, in the order of the event bits below.
  localparam logic [15:0] VT [0:19] = '{16'h0010, 16'h0012, 16'h0036, 16'h0038, 16'h002a, 16'h003a, 16'h003c,
    16'h004a, 16'h0064, 16'h0014, 16'h0010, 16'h0012, 16'h0014, 16'h002a, 16'h0036, 16'h0038, 16'h003a,
    16'h003c, 16'h004a, 16'h0064};
  logic aclk = 1'b0; // System clock.
  logic aresetn = 1'b0; // Reset, active low.
  logic [19:0] ev = 20'h00000; // Event pulses, one bit per source.
  logic [3:0] lv = 4'h0; // PLL and RTC levels.
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, a;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  logic [7:0] sel;
  int n_errors = 0;
  int compares = 0;
  int seed = 34;

  // Free-running clock, 25 ns period.
  always #12.5 aclk = ~aclk;

  svf_link_if link();
  svf_device svf_device_inst(.aclk(aclk), .aresetn(aresetn), .edge_input_4_request(ev[0]),
    .edge_input_5_request(ev[1]), .edge_input_6_request(ev[2]), .edge_input_7_request(ev[3]),
    .edge_input_8_request(ev[4]), .edge_input_9_request(ev[5]), .edge_input_10_request(ev[6]),
    .edge_input_11_request(ev[7]), .edge_input_12_request(ev[8]), .edge_input_13_request(ev[9]),
    .stack_monitor_request(ev[10]), .comparator0_request(ev[11]), .clock_stop_request(ev[12]),
    .rtc_event_request(ev[13]), .timer1_ch1_upper_request(ev[14]), .timer1_ch3_upper_request(ev[15]),
    .timer0_ch1_upper_request(ev[16]), .timer0_ch3_upper_request(ev[17]), .lin_port0_wakeup_request(ev[18]),
    .lin_port1_wakeup_request(ev[19]), .pll_selected_status(lv[0]), .pll_select_control(lv[1]),
    .alarm_match_flag(lv[2]), .periodic_event_flag(lv[3]), .link(link));
  svf_host svf_host_inst(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .link(link));
  svf_props svf_props_inst(.aclk(aclk), .aresetn(aresetn), .vector_valid(link.vector_valid),
    .vector_addr(link.vector_addr), .vector_ack(link.vector_ack), .flag_wr(link.flag_wr),
    .flag_wdata(link.flag_wdata), .flag_rdata(link.flag_rdata), .aux_status(link.aux_status),
    .wake_select(link.wake_select));

  // Compare one value and report a difference at once.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Report the counts, give the verdict and stop.
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One AXI write; each channel is released when taken, the response is awaited.
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask

  // One AXI read; data and response are taken at the edge where rvalid is seen.
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  // A one-cycle event pulse on one source.
  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev <= 20'h00000;
  endtask

  // Flag bit that a source sets; sources without a flag give zero.
  function automatic logic [7:0] fbit(input int i);
    case (i)
      0: return 8'h01;
      1: return 8'h02;
      4: return 8'h04;
      11: return 8'h40;
      9: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction

  // Cut a hang short well beyond the expected run length.
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    conclude();
  end

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SVF_OFS_CTRL, v);
    chk("ctrl reset", v, 32'h0);
    rd(SVF_OFS_FLAGS, v);
    chk("flags reset", v, {24'h0, SVF_FLAGS_RESET});
    rd(8'h40, v);
    chk("unmapped resp", {30'h0, r}, {30'h0, SVF_RESP_SLVERR});
    chk("unmapped data", v, 32'h0);
    wr(8'h40, 32'h0);
    chk("wr unmapped resp", {30'h0, r}, {30'h0, SVF_RESP_SLVERR});
    // Wake-up events of unselected pair members must be ignored.
    wr(SVF_OFS_CTRL, 32'h4);
    pulse(18);
    pulse(19);
    rd(SVF_OFS_STATUS, v);
    chk("unselected wake", v, 32'h0);
    // Every source once, with random pair selection and random PLL and RTC levels.
    for (int i = 0; i < 20; i++)
    begin
      sel = 8'($random(seed));
      if (i == 7 || i == 18) sel[0] = (i == 18);
      if (i == 8 || i == 19) sel[1] = (i == 19);
      lv <= 4'($random(seed));
      wr(SVF_OFS_CTRL, {29'h0, 1'b1, sel[1:0]});
      chk("wr resp", {30'h0, r}, {30'h0, SVF_RESP_OKAY});
      pulse(i);
      rd(SVF_OFS_VECTOR, v);
      chk("vector", v, {15'h0, 1'b1, VT[i]});
      chk("rd resp", {30'h0, r}, {30'h0, SVF_RESP_OKAY});
      rd(SVF_OFS_FLAGS, v);
      chk("flags", v, {24'h0, fbit(i)});
      rd(SVF_OFS_STATUS, v);
      chk("status", v, {30'h0, fbit(i) == 8'h00, 1'b1});
      rd(SVF_OFS_AUX, v);
      chk("aux", v, {28'h0, lv});
      wr(SVF_OFS_MASK, 32'h3);
      a = irq;
      wr(SVF_OFS_MASK, 32'h0);
      chk("irq mask", {31'h0, a ^ irq}, 32'h1);
      wr(SVF_OFS_FLAGS, 32'($random(seed)) | {24'h0, fbit(i)});
      rd(SVF_OFS_FLAGS, v);
      chk("ones kept", v, {24'h0, fbit(i)});
      wr(SVF_OFS_FLAGS, 32'h0);
      // Unmask again so that the cleared status is seen to drop the interrupt.
      wr(SVF_OFS_MASK, 32'h3);
      wr(SVF_OFS_STATUS, 32'h3);
      wr(SVF_OFS_EOI, 32'h1);
      rd(SVF_OFS_FLAGS, v);
      chk("flags cleared", v, 32'h0);
      chk("irq cleared", {31'h0, irq}, 32'h0);
    end
    // A second edge during service re-pends the vector; the re-entry finds no flag.
    pulse(0);
    wr(SVF_OFS_STATUS, 32'h3);
    pulse(0);
    wr(SVF_OFS_FLAGS, 32'h0);
    wr(SVF_OFS_EOI, 32'h1);
    rd(SVF_OFS_VECTOR, v);
    chk("retake", v, 32'h00010010);
    rd(SVF_OFS_STATUS, v);
    chk("retake noflag", v, 32'h3);
    wr(SVF_OFS_STATUS, 32'h3);
    wr(SVF_OFS_EOI, 32'h1);
    // Stack monitor and a timer fire together: the safety vector is taken first.
    @(posedge aclk);
    ev <= 20'h20400;
    @(posedge aclk);
    ev <= 20'h00000;
    rd(SVF_OFS_VECTOR, v);
    chk("priority first", v, 32'h00010010);
    wr(SVF_OFS_EOI, 32'h1);
    rd(SVF_OFS_VECTOR, v);
    chk("priority second", v, 32'h0001003c);
    wr(SVF_OFS_STATUS, 32'h3);
    wr(SVF_OFS_EOI, 32'h1);
    // A clear that meets a new event must never drop the flag.
    ev[4] <= 1'b1;
    repeat (2) @(posedge aclk);
    fork
      wr(SVF_OFS_FLAGS, 32'h0);
      repeat (8)
      begin
        @(posedge aclk);
        chk("set wins", {31'h0, link.flag_rdata[2]}, 32'h1);
      end
    join
    ev <= 20'h00000;
    conclude();
  end
endmodule
`default_nettype wire
